// *** irq_cfg_pkg.sv ***
// constants for the interrupt source conditioning block
// assumes a 16-bit register word and ten interrupt sources
package irq_cfg_pkg;
    localparam int num_sources = 10;
    localparam int reg_width = 16;
    localparam int addr_width = 8;
    // ==========================================================
    // register offsets
    localparam logic [7:0] status_addr = 8'h7f;
    localparam logic [7:0] mask_addr = 8'h80;
    localparam logic [7:0] polarity_addr = 8'h81;
    localparam logic [7:0] debounce_addr = 8'h82;
    // ==========================================================
    // bit positions shared by status, mask, polarity and debounce; combined_irq_bit exists in status only
    localparam int bias_detect_bit = 0;
    localparam int bias_short_bit = 1;
    localparam int loop_lock_bit = 2;
    localparam int left_input_pin_bit = 3;
    localparam int right_input_pin_bit = 4;
    localparam int pin1_bit = 5;
    localparam int pin2_bit = 6;
    localparam int pin3_bit = 7;
    localparam int sequencer_bit = 8;
    localparam int pin4_bit = 9;
    localparam int combined_irq_bit = 10;
    // ==========================================================
    // reset values
    localparam logic [9:0] mask_reset = 10'h3ff;
    localparam logic [9:0] polarity_reset = 10'h000;
    localparam logic [9:0] debounce_reset = 10'h000;
    localparam logic [9:0] status_reset = 10'h000;
    // ==========================================================
    // glitch filter length in system clock samples
    localparam int filter_len_default = 8;
endpackage : irq_cfg_pkg

// *** glitch_filter.sv ***
// glitch filter for one interrupt source
// assumes a synchronised input on the same clock
`timescale 1ns/1ns
module glitch_filter #(
    parameter int filter_len = irq_cfg_pkg::filter_len_default
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic level_in,
    output logic level_out
);
    localparam int cw = $clog2(filter_len + 1);
    localparam logic [cw-1:0] last_count = cw'(filter_len - 1);

    // elaboration check: one sample cannot tell a spike from a level
    if (filter_len < 2) begin : g_len_check
        $error("filter_len must be at least 2");
    end

    logic [cw-1:0] count;
    logic [cw-1:0] next_count;
    logic next_level_out;

    // ==========================================================
    // stability counter
    always_comb begin
        next_count = '0;
        next_level_out = level_out;
        if (level_in != level_out) begin
            if (count == last_count) begin
                next_level_out = level_in;
            end else begin
                next_count = count + cw'(1);
            end
        end
        // a spike that returns before the count expires resets it
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
            level_out <= 1'b0;
        end else begin
            count <= next_count;
            level_out <= next_level_out;
        end
    end
endmodule : glitch_filter

// *** irq_mask_polarity_debounce.sv ***
// interrupt source conditioning: polarity, filter, latch, mask, combined output
// assumes a simple register port from the control interface on the same clock
//
// How it works
// - a mask bit of 1 keeps its source off the combined output.
// - all ten mask bits reset to 1.
// - mask, polarity, debounce share one layout, pin4 bit 9 to detect bit 0.
// - polarity 0 triggers high, 1 triggers low, applied before the status flag.
// - sequencer source fires while busy, or while idle when inverted.
// - lock source fires on lock, or while unlocked when inverted.
// - all polarity bits reset to 0.
// - debounce bit 1 routes source through the filter; resets to 0.
// - status flags latch, clear on written 1, unchanged on written 0.
// - combined output is OR of unmasked latched flags.
// - masked sources still latch and read back their status.
// - with debounce on, short spikes never reach status or output.
`timescale 1ns/1ns
module irq_mask_polarity_debounce #(
    parameter int filter_len = irq_cfg_pkg::filter_len_default
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin1_in,
    input wire logic pin2_in,
    input wire logic pin3_in,
    input wire logic pin4_in,
    input wire logic left_input_pin_in,
    input wire logic right_input_pin_in,
    input wire logic sequencer_busy,
    input wire logic loop_locked,
    input wire logic bias_short,
    input wire logic bias_detect,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic irq
);
    localparam int n = irq_cfg_pkg::num_sources;

    // elaboration check: the filter counter needs at least two samples to
    // tell a spike from a level
    if (filter_len < 2) begin : g_len_check
        $error("filter_len must be at least 2");
    end

    // ==========================================================
    // gather sources in register bit order
    logic [n-1:0] raw;

    always_comb begin
        raw = '0;
        raw[irq_cfg_pkg::pin4_bit] = pin4_in;
        raw[irq_cfg_pkg::sequencer_bit] = sequencer_busy;
        raw[irq_cfg_pkg::pin3_bit] = pin3_in;
        raw[irq_cfg_pkg::pin2_bit] = pin2_in;
        raw[irq_cfg_pkg::pin1_bit] = pin1_in;
        raw[irq_cfg_pkg::right_input_pin_bit] = right_input_pin_in;
        raw[irq_cfg_pkg::left_input_pin_bit] = left_input_pin_in;
        raw[irq_cfg_pkg::loop_lock_bit] = loop_locked;
        raw[irq_cfg_pkg::bias_short_bit] = bias_short;
        raw[irq_cfg_pkg::bias_detect_bit] = bias_detect;
    end

    // ==========================================================
    // three-stage synchroniser; level accepted when stages two and three agree
    // internal sources take the same path: a few cycles of latency, one timing rule
    logic [n-1:0] sync1;
    logic [n-1:0] sync2;
    logic [n-1:0] sync3;
    logic [n-1:0] level;
    logic [n-1:0] next_level;

    always_comb begin
        next_level = level;
        for (int i = 0; i < n; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_level[i] = sync3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            level <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
            level <= next_level;
        end
    end

    // ==========================================================
    // configuration and status registers
    logic [n-1:0] mask;
    logic [n-1:0] polarity;
    logic [n-1:0] debounce;
    logic [n-1:0] status;
    logic [n-1:0] next_mask;
    logic [n-1:0] next_polarity;
    logic [n-1:0] next_debounce;
    logic [n-1:0] next_status;
    logic [15:0] next_reg_rdata;
    logic next_reg_rvalid;
    logic next_irq;

    // ==========================================================
    // polarity before the filter, so the filter judges the trigger level
    logic [n-1:0] active;
    logic [n-1:0] filtered;
    logic [n-1:0] conditioned;

    assign active = level ^ polarity;

    genvar g;
    generate
        for (g = 0; g < n; g++) begin : g_filter
            glitch_filter #(
                .filter_len(filter_len)
            ) u_filter (
                .clk(clk),
                .rst(rst),
                .level_in(active[g]),
                .level_out(filtered[g])
            );
            // filter keeps running while bypassed so enabling it never glitches
            assign conditioned[g] = debounce[g] ? filtered[g] : active[g];
        end
    endgenerate

    function automatic logic [15:0] read_word(
        input logic [7:0] addr,
        input logic [n-1:0] st,
        input logic [n-1:0] mk,
        input logic [n-1:0] pl,
        input logic [n-1:0] db,
        input logic ir
    );
        logic [15:0] w;
        w = '0;
        case (addr)
            irq_cfg_pkg::status_addr: begin
                w[n-1:0] = st;
                w[irq_cfg_pkg::combined_irq_bit] = ir;
            end
            irq_cfg_pkg::mask_addr: begin
                w[n-1:0] = mk;
            end
            irq_cfg_pkg::polarity_addr: begin
                w[n-1:0] = pl;
            end
            irq_cfg_pkg::debounce_addr: begin
                w[n-1:0] = db;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction : read_word

    always_comb begin
        next_mask = mask;
        next_polarity = polarity;
        next_debounce = debounce;
        next_status = status;
        if (reg_wr) begin
            case (reg_addr)
                irq_cfg_pkg::mask_addr: begin
                    next_mask = reg_wdata[n-1:0];
                end
                irq_cfg_pkg::polarity_addr: begin
                    next_polarity = reg_wdata[n-1:0];
                end
                irq_cfg_pkg::debounce_addr: begin
                    next_debounce = reg_wdata[n-1:0];
                end
                irq_cfg_pkg::status_addr: begin
                    next_status = status & ~reg_wdata[n-1:0];
                end
                default: begin
                    next_status = status;
                end
            endcase
        end
        // set wins over a clear in the same cycle; masking does not stop latching
        next_status = next_status | conditioned;
        next_irq = |(next_status & ~next_mask);
        next_reg_rvalid = reg_rd;
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            next_reg_rdata = read_word(reg_addr, status, mask, polarity, debounce, irq);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= irq_cfg_pkg::mask_reset;
            polarity <= irq_cfg_pkg::polarity_reset;
            debounce <= irq_cfg_pkg::debounce_reset;
            status <= irq_cfg_pkg::status_reset;
            irq <= 1'b0;
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            mask <= next_mask;
            polarity <= next_polarity;
            debounce <= next_debounce;
            status <= next_status;
            irq <= next_irq;
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end
endmodule : irq_mask_polarity_debounce

// *** irq_checker_properties.sv ***
// checker for the interrupt conditioning block
// assumes it is bound to the block top and sees only its ports
`timescale 1ns/1ns
module irq_checker_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic irq
);
    // ==========================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_no_answer; !reg_rd |=> !reg_rvalid; endproperty
    a_no_answer: assert property (p_no_answer) else $error("stray read valid");
    property p_rst_quiet; $fell(rst) |-> !irq && !reg_rvalid; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("active after reset");
    property p_unmapped; reg_rd && (reg_addr < 8'h7f || reg_addr > 8'h82) |=> reg_rdata == 16'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_upper; reg_rd && reg_addr != 8'h7f |=> reg_rdata[15:10] == 6'h00; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_irq_bit; reg_rd && reg_addr == 8'h7f |=> reg_rdata[10] == $past(irq); endproperty
    a_irq_bit: assert property (p_irq_bit) else $error("status irq bit wrong");
    // the idle cycle keeps a following unmask write from raising irq legally
    property p_all_masked;
        reg_wr && reg_addr == 8'h80 && reg_wdata[9:0] == 10'h3ff ##1 !reg_wr |=> !irq;
    endproperty
    a_all_masked: assert property (p_all_masked) else $error("irq while all masked");
    property p_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    c_irq: cover property ($rose(irq));
    c_status_rd: cover property (reg_rd && reg_addr == 8'h7f);
    c_mask_wr: cover property (reg_wr && reg_addr == 8'h80);
endmodule : irq_checker_properties
bind irq_mask_polarity_debounce irq_checker_properties u_chk (.clk(clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq(irq));

// *** host_model.sv ***
// host side: counts rising edges of the combined interrupt
// assumes irq is a registered level on clk
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq,
    output int irq_events
);
    // ==========================================================
    // edge count
    logic irq_q;
    always_ff @(posedge clk) begin
        irq_q <= rst ? 1'b0 : irq;
        irq_events <= rst ? 0 : irq_events + int'(irq && !irq_q);
    end
endmodule : host_model

// *** tb.sv ***
// testbench for the interrupt conditioning block
// assumes checker bound to the top and filter length set to 4
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
    // ==========================================================
    // signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] src = 10'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic irq;
    int irq_events;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    initial forever #10 clk = ~clk;
    irq_mask_polarity_debounce #(.filter_len(4)) u_dut (.clk(clk), .rst(rst),
        .pin1_in(src[5]), .pin2_in(src[6]), .pin3_in(src[7]), .pin4_in(src[9]),
        .left_input_pin_in(src[3]), .right_input_pin_in(src[4]), .sequencer_busy(src[8]),
        .loop_locked(src[2]), .bias_short(src[1]), .bias_detect(src[0]), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .irq(irq));
    host_model u_host (.clk(clk), .rst(rst), .irq(irq), .irq_events(irq_events));
    // ==========================================================
    // bus tasks
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, reg_rvalid)
        `CHK("rdata", e, reg_rdata)
    endtask : rd
    // sync plus a filter of 4 needs about 9 edges
    task automatic settle();
        repeat (12) @(posedge clk);
    endtask : settle
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd(8'h80, 16'h03ff);
        rd(8'h81, 16'h0000);
        rd(8'h82, 16'h0000);
        rd(8'h83, 16'h0000);
        wr(8'h82, 16'hfd55);
        rd(8'h82, 16'h0155);
        wr(8'h82, 16'h0000);
        $display("reset test done");
    endtask : t_reset
    task automatic t_mask();
        wr(8'h80, 16'h03fe);
        @(posedge clk) src[0] <= 1'b1;
        settle();
        `CHK("irq", 1'b1, irq)
        rd(8'h7f, 16'h0401);
        @(posedge clk) src[9] <= 1'b1;
        @(posedge clk) src[0] <= 1'b0;
        settle();
        rd(8'h7f, 16'h0601);
        wr(8'h80, 16'h03ff);
        rd(8'h7f, 16'h0201);
        wr(8'h80, 16'h03fe);
        wr(8'h7f, 16'h0001);
        settle();
        `CHK("irq", 1'b0, irq)
        @(posedge clk) src[9] <= 1'b0;
        settle();
        // source now idle, so only the latch can keep the flag
        wr(8'h7f, 16'h0000);
        rd(8'h7f, 16'h0200);
        wr(8'h7f, 16'h0200);
        rd(8'h7f, 16'h0000);
        `CHK("events", 2, irq_events)
        $display("mask test done");
    endtask : t_mask
    task automatic t_polarity();
        wr(8'h81, 16'h0100);
        settle();
        rd(8'h7f, 16'h0100);
        wr(8'h81, 16'h0000);
        @(posedge clk) src[8] <= 1'b1;
        settle();
        wr(8'h7f, 16'h0100);
        rd(8'h7f, 16'h0100);
        @(posedge clk) src[8] <= 1'b0;
        @(posedge clk) src[2] <= 1'b1;
        settle();
        rd(8'h7f, 16'h0104);
        wr(8'h81, 16'h0004);
        settle();
        wr(8'h7f, 16'h0104);
        settle();
        rd(8'h7f, 16'h0000);
        @(posedge clk) src[2] <= 1'b0;
        settle();
        rd(8'h7f, 16'h0004);
        wr(8'h81, 16'h0000);
        settle();
        wr(8'h7f, 16'h0004);
        $display("polarity test done");
    endtask : t_polarity
    task automatic t_filter();
        wr(8'h82, 16'h0020);
        // one sample short of the filter length must be rejected
        @(posedge clk) src[5] <= 1'b1;
        repeat (3) @(posedge clk);
        src[5] <= 1'b0;
        settle();
        rd(8'h7f, 16'h0000);
        // exactly the filter length must be accepted
        @(posedge clk) src[5] <= 1'b1;
        repeat (4) @(posedge clk);
        src[5] <= 1'b0;
        settle();
        rd(8'h7f, 16'h0020);
        $display("filter test done");
    endtask : t_filter
    // ==========================================================
    // run control
    task automatic results();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    // the whole run is well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_mask();
        t_polarity();
        t_filter();
        results();
    end
endmodule : tb
